//--- stlms_top.sv
// torque limit selection, clamp, limiting status and control mode pair select
//
// How it works
// R1: with an external limit on and analog limiting set, take lesser of analog and external.
// R2: no analog limiting in torque mode, the analog input is the command there.
// R3: option digit 3 uses the analog input as a limit only while an external limit is on.
// R4: option digit 2 makes the analog input feed-forward, never a limit at the same time.
// R5: analog input is scaled by the gain register before any use.
// R6: forward input low gives lesser of internal and external forward limit, else internal.
// R7: reverse input low gives lesser of internal and external reverse limit, else internal.
// R8: functions mapped to one terminal are asserted together whenever that terminal is active.
// R9: limiting output is low while torque is clamped, high otherwise.
// R10: limiting output reaches a terminal only when the output map assigns one.
// R11: mode digits 4 to 9 select the documented control mode pairs.
// R12: mode digit A pairs speed with zero clamp, B position with pulse inhibit.
// R13: limit values count in percent of rated torque, 100 meaning full rated torque.
// R14: analog limit uses the input magnitude and applies to both directions.
// R15: the mode switch input level picks one mode of the selected pair.
// R16: the command is clamped every cycle and limiting is flagged on each clamp.
`timescale 1ns/1ns
`include "stlms_consts.svh"
module stlms_top (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] terminal_in_n,
    input wire logic [15:0] torque_ref_sample,
    input wire logic [15:0] torque_cmd_in,
    output logic [15:0] torque_cmd_out,
    output logic [15:0] torque_ff_out,
    output stlms_pkg::stlms_mode_type active_mode,
    output logic limiting_active_n,
    output logic [2:0] out_terminal_n
);
    import stlms_pkg::*;

    stlms_top_state_type s_reg;
    stlms_top_state_type s_next;
    stlms_lim_if fwd_if ();
    stlms_lim_if rev_if ();

    logic [3:0] opt;
    logic [3:0] pair;
    logic torque_mode;
    logic fwd_limit_input_n;
    logic rev_limit_input_n;
    logic mode_switch_input_n;
    logic ana_fwd_on;
    logic ana_rev_on;
    logic [15:0] mag;
    logic [31:0] prod;
    logic [23:0] scaled;
    logic [14:0] mag_sat;
    logic signed [16:0] cmd17;
    logic signed [16:0] pos17;
    logic signed [16:0] neg17;
    logic over_pos;
    logic over_neg;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] strb);
        logic [15:0] v;
        v = old;
        if (strb[0]) begin
            v[7:0] = d[7:0];
        end
        if (strb[1]) begin
            v[15:8] = d[15:8];
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // a terminal may carry several functions; any active mapped terminal asserts each
    assign fwd_limit_input_n = ~|(~s_reg.term_s2 & s_reg.in_map[`STLMS_FWD_MASK_LSB +: 4]); // [R8]
    assign rev_limit_input_n = ~|(~s_reg.term_s2 & s_reg.in_map[`STLMS_REV_MASK_LSB +: 4]); // [R8]
    assign mode_switch_input_n = ~|(~s_reg.term_s2 & s_reg.in_map[`STLMS_MSW_MASK_LSB +: 4]); // [R8]

    assign opt = s_reg.option[`STLMS_DIGIT_LSB +: 4];
    assign pair = s_reg.mode_pair[`STLMS_DIGIT_LSB +: 4];
    assign torque_mode = (s_reg.mode == MODE_TRQ);
    // feed-forward digit never enables limiting, so the two uses stay exclusive
    assign ana_fwd_on = !torque_mode && ((opt == `STLMS_OPT_ANA_LIMIT) || // [R2] [R4]
        ((opt == `STLMS_OPT_ANA_ON_EXT) && s_reg.fwd_on)); // [R3]
    assign ana_rev_on = !torque_mode && ((opt == `STLMS_OPT_ANA_LIMIT) || // [R2] [R4]
        ((opt == `STLMS_OPT_ANA_ON_EXT) && s_reg.rev_on)); // [R3]

    // magnitude only, so one analog limit serves both directions
    assign mag = torque_ref_sample[15] ? 16'(-torque_ref_sample) : torque_ref_sample; // [R14]
    assign prod = 32'(mag) * 32'(s_reg.gain); // [R5]
    assign scaled = 24'(prod >> `STLMS_GAIN_SHIFT); // [R5]
    assign mag_sat = (|scaled[23:15]) ? 15'h7FFF : scaled[14:0];

    assign fwd_if.internal = s_reg.int_fwd;
    assign fwd_if.external = s_reg.ext_fwd;
    assign fwd_if.analog = s_reg.ana_lim; // [R14]
    assign fwd_if.ext_on = s_reg.fwd_on;
    assign fwd_if.analog_on = ana_fwd_on;
    assign rev_if.internal = s_reg.int_rev;
    assign rev_if.external = s_reg.ext_rev;
    assign rev_if.analog = s_reg.ana_lim; // [R14]
    assign rev_if.ext_on = s_reg.rev_on;
    assign rev_if.analog_on = ana_rev_on;

    stlms_limit_sel u_fwd_sel (
        .mclk(mclk),
        .arst_n(arst_n),
        .lim(fwd_if)
    );

    stlms_limit_sel u_rev_sel (
        .mclk(mclk),
        .arst_n(arst_n),
        .lim(rev_if)
    );

    // in torque mode the scaled analog input is the command itself
    assign cmd17 = torque_mode ? 17'(signed'(s_reg.ana_cmd)) : // [R2] [R5]
        (opt == `STLMS_OPT_FEED_FWD) ? 17'(signed'(torque_cmd_in)) + 17'(signed'(s_reg.ana_cmd)) : // [R4]
        17'(signed'(torque_cmd_in));
    assign pos17 = signed'({1'b0, fwd_if.limit});
    assign neg17 = 17'(-signed'({1'b0, rev_if.limit}));
    assign over_pos = cmd17 > pos17; // [R16]
    assign over_neg = cmd17 < neg17; // [R16]

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_next = s_reg;
        s_next.term_s1 = terminal_in_n;
        s_next.term_s2 = s_reg.term_s1;
        s_next.fwd_on = !fwd_limit_input_n; // [R6]
        s_next.rev_on = !rev_limit_input_n; // [R7]
        s_next.msw_on = !mode_switch_input_n;
        // switch on selects the first mode of pairs 4 to 6 and the second mode of pairs 7 to B [R15]
        unique case (pair)
            `STLMS_PAIR_ISPD_SPD: s_next.mode = s_reg.msw_on ? MODE_ISPD : MODE_SPD; // [R11]
            `STLMS_PAIR_ISPD_POS: s_next.mode = s_reg.msw_on ? MODE_ISPD : MODE_POS; // [R11]
            `STLMS_PAIR_ISPD_TRQ: s_next.mode = s_reg.msw_on ? MODE_ISPD : MODE_TRQ; // [R11]
            `STLMS_PAIR_POS_SPD: s_next.mode = s_reg.msw_on ? MODE_SPD : MODE_POS; // [R11]
            `STLMS_PAIR_POS_TRQ: s_next.mode = s_reg.msw_on ? MODE_TRQ : MODE_POS; // [R11]
            `STLMS_PAIR_TRQ_SPD: s_next.mode = s_reg.msw_on ? MODE_SPD : MODE_TRQ; // [R11]
            `STLMS_PAIR_SPD_ZCL: s_next.mode = s_reg.msw_on ? MODE_ZCLAMP : MODE_SPD; // [R12]
            `STLMS_PAIR_POS_INH: s_next.mode = s_reg.msw_on ? MODE_PINH : MODE_POS; // [R12]
            `STLMS_SINGLE_POS: s_next.mode = MODE_POS;
            `STLMS_SINGLE_TRQ: s_next.mode = MODE_TRQ;
            `STLMS_SINGLE_ISPD: s_next.mode = MODE_ISPD;
            default: s_next.mode = MODE_SPD;
        endcase
        s_next.ana_lim = {1'b0, mag_sat}; // [R5] [R14]
        s_next.ana_cmd = torque_ref_sample[15] ? 16'(-{1'b0, mag_sat}) : {1'b0, mag_sat}; // [R5]
        s_next.ff_out = (!torque_mode && (opt == `STLMS_OPT_FEED_FWD)) ? s_reg.ana_cmd : 16'h0000; // [R4]
        // limits above 32767 would wrap; parameter range keeps them far below
        s_next.torque_out = over_pos ? pos17[15:0] : over_neg ? neg17[15:0] : cmd17[15:0]; // [R16]
        s_next.lim_n = !(over_pos || over_neg); // [R9] [R16]
        for (int i = 0; i < 3; i++) begin
            s_next.term_out_n[i] = !((s_reg.status_map[1:0] == 2'(i + 1)) && (over_pos || over_neg)); // [R10]
        end

        // register bus: address and data in either order, response after both
        if (s_axi_awvalid && s_reg.awready) begin
            s_next.aw_addr = s_axi_awaddr;
            s_next.aw_have = 1'b1;
            s_next.awready = 1'b0;
        end
        if (s_axi_wvalid && s_reg.wready) begin
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
            s_next.w_have = 1'b1;
            s_next.wready = 1'b0;
        end
        if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid) begin
            s_next.aw_have = 1'b0;
            s_next.w_have = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = `STLMS_RESP_OKAY;
            case (s_reg.aw_addr)
                `STLMS_OFF_MODE_PAIR: s_next.mode_pair = merge16(s_reg.mode_pair, s_reg.w_data, s_reg.w_strb);
                `STLMS_OFF_OPTION: s_next.option = merge16(s_reg.option, s_reg.w_data, s_reg.w_strb);
                `STLMS_OFF_GAIN: s_next.gain = merge16(s_reg.gain, s_reg.w_data, s_reg.w_strb);
                `STLMS_OFF_INT_FWD: s_next.int_fwd = merge16(s_reg.int_fwd, s_reg.w_data, s_reg.w_strb);
                `STLMS_OFF_INT_REV: s_next.int_rev = merge16(s_reg.int_rev, s_reg.w_data, s_reg.w_strb);
                `STLMS_OFF_EXT_FWD: s_next.ext_fwd = merge16(s_reg.ext_fwd, s_reg.w_data, s_reg.w_strb);
                `STLMS_OFF_EXT_REV: s_next.ext_rev = merge16(s_reg.ext_rev, s_reg.w_data, s_reg.w_strb);
                `STLMS_OFF_STATUS_MAP: s_next.status_map = merge16(s_reg.status_map, s_reg.w_data, s_reg.w_strb);
                `STLMS_OFF_INPUT_MAP: s_next.in_map = merge16(s_reg.in_map, s_reg.w_data, s_reg.w_strb);
                `STLMS_OFF_STATUS, `STLMS_OFF_LIMITS: s_next.bresp = `STLMS_RESP_OKAY;
                default: s_next.bresp = `STLMS_RESP_SLVERR;
            endcase
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
            s_next.awready = 1'b1;
            s_next.wready = 1'b1;
        end
        if (s_axi_arvalid && s_reg.arready) begin
            s_next.arready = 1'b0;
            s_next.rvalid = 1'b1;
            s_next.rresp = `STLMS_RESP_OKAY;
            case (s_axi_araddr)
                `STLMS_OFF_MODE_PAIR: s_next.rdata = {16'h0000, s_reg.mode_pair};
                `STLMS_OFF_OPTION: s_next.rdata = {16'h0000, s_reg.option};
                `STLMS_OFF_GAIN: s_next.rdata = {16'h0000, s_reg.gain};
                `STLMS_OFF_INT_FWD: s_next.rdata = {16'h0000, s_reg.int_fwd};
                `STLMS_OFF_INT_REV: s_next.rdata = {16'h0000, s_reg.int_rev};
                `STLMS_OFF_EXT_FWD: s_next.rdata = {16'h0000, s_reg.ext_fwd};
                `STLMS_OFF_EXT_REV: s_next.rdata = {16'h0000, s_reg.ext_rev};
                `STLMS_OFF_STATUS_MAP: s_next.rdata = {16'h0000, s_reg.status_map};
                `STLMS_OFF_INPUT_MAP: s_next.rdata = {16'h0000, s_reg.in_map};
                `STLMS_OFF_STATUS: s_next.rdata = {24'h000000, 1'b0, s_reg.mode, s_reg.lim_n,
                    s_reg.msw_on, s_reg.rev_on, s_reg.fwd_on};
                `STLMS_OFF_LIMITS: s_next.rdata = {rev_if.limit, fwd_if.limit};
                default: begin
                    s_next.rdata = 32'h00000000;
                    s_next.rresp = `STLMS_RESP_SLVERR;
                end
            endcase
        end
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
            s_next.arready = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
            s_reg.awready <= 1'b1;
            s_reg.wready <= 1'b1;
            s_reg.arready <= 1'b1;
            s_reg.mode_pair <= `STLMS_RST_MODE_PAIR;
            s_reg.option <= `STLMS_RST_OPTION;
            s_reg.gain <= `STLMS_RST_GAIN;
            s_reg.int_fwd <= `STLMS_RST_INT_LIMIT;
            s_reg.int_rev <= `STLMS_RST_INT_LIMIT;
            s_reg.ext_fwd <= `STLMS_RST_EXT_LIMIT;
            s_reg.ext_rev <= `STLMS_RST_EXT_LIMIT;
            s_reg.status_map <= `STLMS_RST_STATUS_MAP;
            s_reg.in_map <= `STLMS_RST_INPUT_MAP;
            s_reg.term_s1 <= 4'hF;
            s_reg.term_s2 <= 4'hF;
            s_reg.lim_n <= 1'b1;
            s_reg.term_out_n <= 3'h7;
        end else begin
            s_reg <= s_next;
        end
    end

    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rresp = s_reg.rresp;
    assign s_axi_rdata = s_reg.rdata;
    assign torque_cmd_out = s_reg.torque_out;
    assign torque_ff_out = s_reg.ff_out;
    assign active_mode = s_reg.mode;
    assign limiting_active_n = s_reg.lim_n;
    assign out_terminal_n = s_reg.term_out_n;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence seq_fwd_terminal;
        |(~s_reg.term_s2 & s_reg.in_map[`STLMS_FWD_MASK_LSB +: 4]);
    endsequence

    sequence seq_clamping;
        over_pos || over_neg;
    endsequence

    AST_OR_TERMINAL: assert property (seq_fwd_terminal |=> s_reg.fwd_on) // [R8]
        else $error("mapped terminal did not assert forward limit");
    AST_NO_ANA_TORQUE: assert property (torque_mode |-> !ana_fwd_on && !ana_rev_on) // [R2]
        else $error("analog limiting in torque mode");
    AST_OPT3_GATED: assert property ((opt == `STLMS_OPT_ANA_ON_EXT) && !s_reg.fwd_on |-> !ana_fwd_on) // [R3]
        else $error("analog limit without external limit under option 3");
    AST_FF_EXCL: assert property ((opt == `STLMS_OPT_FEED_FWD) |-> !ana_fwd_on && !ana_rev_on) // [R4]
        else $error("feed-forward and analog limit together");
    AST_STATUS_LOW: assert property (seq_clamping |=> !limiting_active_n ##1 limiting_active_n == $past(s_next.lim_n)) // [R9]
        else $error("limiting output not low during clamp");
    AST_CLAMP_BOUND: assert property (##1 (signed'({torque_cmd_out[15], torque_cmd_out}) <= $past(pos17)) && // [R16]
        (signed'({torque_cmd_out[15], torque_cmd_out}) >= $past(neg17)))
        else $error("command outside selected limits");
    AST_TERM_UNMAPPED: assert property ((s_reg.status_map[1:0] == 2'h0) |=> out_terminal_n == 3'h7) // [R10]
        else $error("unassigned limiting output drives a terminal");
    AST_PAIR7: assert property ((pair == `STLMS_PAIR_POS_SPD) && s_reg.msw_on |=> active_mode == MODE_SPD) // [R11] [R15]
        else $error("pair 7 switch on did not select speed");
    AST_PAIR_B: assert property ((pair == `STLMS_PAIR_POS_INH) && s_reg.msw_on |=> active_mode == MODE_PINH) // [R12]
        else $error("pair B switch on did not select inhibit");
endmodule

//--- stlms_consts.svh
// register offsets, field positions, reset values and codes of the torque limit block
`ifndef STLMS_CONSTS_SVH
`define STLMS_CONSTS_SVH

`define STLMS_OFF_MODE_PAIR 8'h00
`define STLMS_OFF_OPTION 8'h04
`define STLMS_OFF_GAIN 8'h08
`define STLMS_OFF_INT_FWD 8'h0C
`define STLMS_OFF_INT_REV 8'h10
`define STLMS_OFF_EXT_FWD 8'h14
`define STLMS_OFF_EXT_REV 8'h18
`define STLMS_OFF_STATUS_MAP 8'h1C
`define STLMS_OFF_INPUT_MAP 8'h20
`define STLMS_OFF_STATUS 8'h24
`define STLMS_OFF_LIMITS 8'h28

`define STLMS_DIGIT_LSB 4
`define STLMS_FWD_MASK_LSB 0
`define STLMS_REV_MASK_LSB 4
`define STLMS_MSW_MASK_LSB 8
`define STLMS_GAIN_SHIFT 8

`define STLMS_RST_MODE_PAIR 16'h0000
`define STLMS_RST_OPTION 16'h0000
`define STLMS_RST_GAIN 16'h0100
`define STLMS_RST_INT_LIMIT 16'h012C
`define STLMS_RST_EXT_LIMIT 16'h0064
`define STLMS_RST_STATUS_MAP 16'h0000
`define STLMS_RST_INPUT_MAP 16'h0421

`define STLMS_OPT_ANA_LIMIT 4'h1
`define STLMS_OPT_FEED_FWD 4'h2
`define STLMS_OPT_ANA_ON_EXT 4'h3

`define STLMS_PAIR_ISPD_SPD 4'h4
`define STLMS_PAIR_ISPD_POS 4'h5
`define STLMS_PAIR_ISPD_TRQ 4'h6
`define STLMS_PAIR_POS_SPD 4'h7
`define STLMS_PAIR_POS_TRQ 4'h8
`define STLMS_PAIR_TRQ_SPD 4'h9
`define STLMS_PAIR_SPD_ZCL 4'hA
`define STLMS_PAIR_POS_INH 4'hB
`define STLMS_SINGLE_POS 4'h1
`define STLMS_SINGLE_TRQ 4'h2
`define STLMS_SINGLE_ISPD 4'h3

`define STLMS_RESP_OKAY 2'h0
`define STLMS_RESP_SLVERR 2'h2

`endif

//--- stlms_pkg.sv
// types of the torque limit and control mode block
package stlms_pkg;

    typedef enum logic [2:0] {
        MODE_SPD = 3'b000,
        MODE_POS = 3'b001,
        MODE_TRQ = 3'b010,
        MODE_ISPD = 3'b011,
        MODE_ZCLAMP = 3'b100,
        MODE_PINH = 3'b101
    } stlms_mode_type;

    typedef struct packed {
        logic [15:0] limit;
    } stlms_sel_state_type;

    typedef struct packed {
        logic [7:0] aw_addr;
        logic aw_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic w_have;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [15:0] mode_pair;
        logic [15:0] option;
        logic [15:0] gain;
        logic [15:0] int_fwd;
        logic [15:0] int_rev;
        logic [15:0] ext_fwd;
        logic [15:0] ext_rev;
        logic [15:0] status_map;
        logic [15:0] in_map;
        logic [3:0] term_s1;
        logic [3:0] term_s2;
        logic fwd_on;
        logic rev_on;
        logic msw_on;
        stlms_mode_type mode;
        logic [15:0] ana_lim;
        logic [15:0] ana_cmd;
        logic [15:0] torque_out;
        logic [15:0] ff_out;
        logic lim_n;
        logic [2:0] term_out_n;
    } stlms_top_state_type;

endpackage

//--- stlms_lim_if.sv
// limit sources and selected limit of one rotation direction
`timescale 1ns/1ns
interface stlms_lim_if;
    logic [15:0] internal;
    logic [15:0] external;
    logic [15:0] analog;
    logic ext_on;
    logic analog_on;
    logic [15:0] limit;
    modport sel (input internal, input external, input analog, input ext_on, input analog_on, output limit);
    modport top (output internal, output external, output analog, output ext_on, output analog_on, input limit);
endinterface

//--- stlms_limit_sel.sv
// torque limit selector for one rotation direction
`timescale 1ns/1ns
`include "stlms_consts.svh"
module stlms_limit_sel (
    input wire logic mclk,
    input wire logic arst_n,
    stlms_lim_if.sel lim
);
    import stlms_pkg::*;

    stlms_sel_state_type s_reg;
    stlms_sel_state_type s_next;
    logic [15:0] cap;

    always_comb begin
        s_next = s_reg;
        cap = lim.internal;
        // both sources in percent of rated torque, so a plain compare works [R13]
        if (lim.ext_on && (lim.external < cap)) begin // [R6] [R7]
            cap = lim.external;
        end
        if (lim.analog_on && (lim.analog < cap)) begin // [R1]
            cap = lim.analog;
        end
        s_next.limit = cap;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg.limit <= `STLMS_RST_INT_LIMIT;
        end else begin
            s_reg <= s_next;
        end
    end

    assign lim.limit = s_reg.limit;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence seq_ext_only;
        lim.ext_on && !lim.analog_on;
    endsequence

    sequence seq_ext_and_ana;
        lim.ext_on && lim.analog_on;
    endsequence

    AST_EXT_LESSER: assert property (seq_ext_only |=> // [R6] [R7]
        lim.limit == (($past(lim.external) < $past(lim.internal)) ? $past(lim.external) : $past(lim.internal)))
        else $error("external limit not the lesser value");
    AST_ANA_LESSER: assert property (seq_ext_and_ana |=> // [R1]
        (lim.limit <= $past(lim.analog)) && (lim.limit <= $past(lim.external)))
        else $error("analog plus external limit not respected");
    AST_INT_ONLY: assert property ((!lim.ext_on && !lim.analog_on) |=> lim.limit == $past(lim.internal)) // [R6] [R7]
        else $error("internal limit alone not applied");
endmodule

//--- stlms_host_model.sv
// host controller model driving the servo input terminals
`timescale 1ns/1ns
module stlms_host_model (
    input wire logic mclk,
    input wire logic [3:0] req_n,
    output logic [3:0] terminal_in_n
);
    // levels move just after an edge, like a real host output stage
    always_ff @(posedge mclk) terminal_in_n <= req_n;
endmodule

//--- tb_servo_torque_limit_mode_select.sv
// self-checking bench of the torque limit and control mode block
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_servo_torque_limit_mode_select;
    import stlms_pkg::*;
    logic mclk, arst_n, awv, wv, bry, arv, rry;
    logic [7:0] awa, ara;
    logic [31:0] wd;
    logic [15:0] ana, cmd, seed;
    logic [3:0] req_n;
    wire logic awr, wr, bv, arr, rv, lim_n;
    wire logic [1:0] br, rr;
    wire logic [31:0] rd;
    wire logic [3:0] tin_n;
    wire logic [15:0] tout, ff;
    wire logic [2:0] otn;
    wire stlms_mode_type am;
    int error_cnt, checks_done, mg, mo, gn, ef, er, sm, im;
    ////////////////////////////////////////////////////////////////
    stlms_host_model host (.mclk(mclk), .req_n(req_n), .terminal_in_n(tin_n));
    stlms_top dut (.mclk(mclk), .arst_n(arst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .terminal_in_n(tin_n),
        .torque_ref_sample(ana), .torque_cmd_in(cmd), .torque_cmd_out(tout), .torque_ff_out(ff),
        .active_mode(am), .limiting_active_n(lim_n), .out_terminal_n(otn));
    ////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic int mn(input int a, input int b);
        return a < b ? a : b;
    endfunction
    // first mode of pairs 4 to 6, second mode of pairs 7 to 11, is the one picked with the switch on
    function automatic int mtab(input int d, input logic on);
        case (d)
            1: return 1;
            2: return 2;
            3: return 3;
            4: return on ? 3 : 0;
            5: return on ? 3 : 1;
            6: return on ? 3 : 2;
            7: return on ? 0 : 1;
            8: return on ? 2 : 1;
            9: return on ? 0 : 2;
            10: return on ? 4 : 0;
            11: return on ? 5 : 1;
            default: return 0;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////
    // waits for the answer however long it takes; only the watchdog ends a hang
    task automatic axw(input logic [7:0] a, input int d, input logic [1:0] e);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge mclk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv);
        bry <= 1'b0;
        `CHK(br, e)
        @(posedge mclk);
    endtask
    task automatic axr(input logic [7:0] a, input int d, input logic [1:0] e);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge mclk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rry <= 1'b0;
        `CHK(rd, 32'(d))
        `CHK(rr, e)
        @(posedge mclk);
    endtask
    task automatic cfg(input int m, input int o, input int g, input int s);
        mg = m;
        mo = o;
        gn = g;
        sm = s;
        axw(8'h00, m << 4, 2'h0);
        axw(8'h04, o << 4, 2'h0);
        axw(8'h08, g, 2'h0);
        axw(8'h1C, s, 2'h0);
    endtask
    // drive levels, let the sync and clamp pipeline settle, compare with the model
    task automatic run(input int c, input int a, input logic [3:0] t);
        int fl, rl, s, o, md, x, ax;
        logic fo, ro, lm, tq;
        cmd <= 16'(c);
        ana <= 16'(a);
        req_n <= t;
        repeat (10) @(posedge mclk);
        fo = |(4'(im) & ~t);
        ro = |(4'(im >> 4) & ~t);
        md = mtab(mg, |(4'(im >> 8) & ~t));
        tq = (md == 2);
        x = a * gn / 256;
        ax = (a < 0 ? -a : a) * gn / 256;
        fl = fo ? mn(300, ef) : 300;
        rl = ro ? mn(300, er) : 300;
        if (!tq && (mo == 1 || (mo == 3 && fo))) fl = mn(fl, ax);
        if (!tq && (mo == 1 || (mo == 3 && ro))) rl = mn(rl, ax);
        // feed-forward adds the scaled analog input to the command before the clamp
        s = tq ? x : ((mo == 2) ? c + x : c);
        o = s > fl ? fl : (s < -rl ? -rl : s);
        lm = (o != s);
        `CHK(tout, 16'(o))
        `CHK(lim_n, !lm)
        `CHK(ff, 16'((mo == 2 && !tq) ? x : 0))
        `CHK(am, 3'(md))
        `CHK(otn, 3'b111 & ~((lm && sm != 0) ? 3'(1 << (sm - 1)) : 3'b000))
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        print_verdict();
    end
    initial begin
        {arst_n, awv, wv, bry, arv, rry, awa, ara, wd, ana, cmd} = '0;
        {error_cnt, checks_done, mg, mo, sm} = '0;
        req_n = 4'hF;
        seed = 16'h0061;
        im = 32'h421;
        gn = 256;
        ef = 80;
        er = 60;
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        axr(8'h08, 32'h100, 2'h0);
        axr(8'h10, 300, 2'h0);
        axr(8'h14, 100, 2'h0);
        axr(8'h20, 32'h421, 2'h0);
        axr(8'h30, 0, 2'h2);
        axw(8'h3C, 5, 2'h2);
        axw(8'h14, ef, 2'h0);
        axw(8'h18, er, 2'h0);
        cfg(0, 0, 256, 1);
        run(300, 0, 4'hF);
        run(301, 0, 4'hF);
        run(200, 0, 4'hE);
        axr(8'h28, 32'h012C0050, 2'h0);
        axr(8'h24, 32'h00000001, 2'h0);
        run(-200, 0, 4'hD);
        repeat (8) begin
            seed = lfsr(seed);
            run(int'(seed[9:0]) - 512, 0, {2'b11, seed[11:10]});
        end
        im = 32'h4A9;
        axw(8'h20, im, 2'h0);
        run(100, 0, 4'h7);
        run(-100, 0, 4'h7);
        cfg(0, 1, 512, 2);
        run(300, -20, 4'hF);
        cfg(0, 3, 512, 3);
        run(300, -20, 4'hF);
        run(300, -20, 4'hE);
        cfg(0, 2, 512, 2);
        run(50, -20, 4'hF);
        for (int d = 0; d < 12; d++) begin
            cfg(d, 1, 512, 0);
            run(250, 100, 4'hB);
            run(250, 100, 4'hF);
        end
        print_verdict();
    end
endmodule
